// ---- logic/pcmc_pkg.sv ----
// Register map, field layout and reset values of the pace and CM config
package pcmc_pkg;
   localparam int          ADDR_W      = 12;
   localparam int          DATA_W      = 32;
   localparam int          REG_W       = 24;
   localparam int          LANES       = 3;
   localparam int          BYTE_W      = 8;
   localparam int          DRV_W       = 6;
   // Printed register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] PACE_IDX  = 12'h004;
   localparam logic [ADDR_W-1:0] CMREF_IDX = 12'h005;
   localparam logic [ADDR_W-1:0] PACE_ADDR = PACE_IDX << 2;
   localparam logic [ADDR_W-1:0] CMREF_ADDR = CMREF_IDX << 2;
   localparam logic [1:0]  ALIGN_OK    = 2'h0;
   localparam logic [REG_W-1:0] PACE_RST  = 24'h000F88;
   localparam logic [REG_W-1:0] PACE_MASK = 24'h000FFF;
   localparam logic [REG_W-1:0] CMREF_RST = 24'hE00000;
   localparam logic [REG_W-1:0] CMREF_MASK = 24'hF87FF4;
   localparam logic [DATA_W-REG_W-1:0] PAD_ZERO = 8'h00;
   // Pace control fields
   localparam int          FILT_W_BIT  = 11;
   localparam int          FILT_2_BIT  = 10;
   localparam int          FILT_1_BIT  = 9;
   localparam int          SEL3_MSB    = 8;
   localparam int          SEL3_LSB    = 7;
   localparam int          SEL2_MSB    = 6;
   localparam int          SEL2_LSB    = 5;
   localparam int          SEL1_MSB    = 4;
   localparam int          SEL1_LSB    = 3;
   localparam int          DET3_BIT    = 2;
   localparam int          DET2_BIT    = 1;
   localparam int          DET1_BIT    = 0;
   // Common-mode and reference fields
   localparam int          CM_MSB      = 23;
   localparam int          CM_LSB      = 19;
   localparam int          SUM_MSB     = 14;
   localparam int          SUM_LSB     = 9;
   localparam int          CEREF_BIT   = 8;
   localparam int          DSEL_MSB    = 7;
   localparam int          DSEL_LSB    = 4;
   localparam int          EXTERNAL_COMMON_MODE_SELECT_BIT   = 2;
   localparam logic [4:0]  CM_NONE     = 5'h00;
   // Lead codes for the pace detectors
   typedef enum logic [1:0] {
      PCMC_LEAD_I   = 2'b00,
      PCMC_LEAD_II  = 2'b01,
      PCMC_LEAD_III = 2'b10,
      PCMC_LEAD_AVF = 2'b11
   } pcmc_lead_t;
   // Drive electrode codes; higher codes are reserved
   typedef enum logic [3:0] {
      PCMC_DRV_OUT = 4'b0000,
      PCMC_DRV_LA  = 4'b0001,
      PCMC_DRV_LL  = 4'b0010,
      PCMC_DRV_RA  = 4'b0011,
      PCMC_DRV_V1  = 4'b0100,
      PCMC_DRV_V2  = 4'b0101
   } pcmc_drv_t;
   localparam logic [DRV_W-1:0] DRV_NONE = 6'h00;
   localparam logic [DRV_W-1:0] DRV_ONE  = 6'h01;
endpackage

// ---- logic/pcmc_config.sv ----
// APB register bank for pace detection and common-mode/reference control
module pcmc_config (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [pcmc_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [pcmc_pkg::DATA_W-1:0]   pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic                               pready,
   output logic      [pcmc_pkg::DATA_W-1:0]   prdata,
   output logic                               pslverr,
   output logic                               pulse_width_filter_enable,
   output logic                               second_validation_filter_enable,
   output logic                               first_validation_filter_enable,
   output logic      [1:0]                    detector_three_lead_select,
   output logic      [1:0]                    detector_two_lead_select,
   output logic      [1:0]                    detector_one_lead_select,
   output logic                               detector_three_enable,
   output logic                               detector_two_enable,
   output logic                               detector_one_enable,
   output logic      [4:0]                    cm_electrode_switch,
   output logic                               internal_common_mode_level,
   output logic                               external_common_mode_select,
   output logic      [5:0]                    drive_sum_switch,
   output logic                               common_electrode_reference_enable,
   output logic      [pcmc_pkg::DRV_W-1:0]    drive_electrode_onehot
);
   import pcmc_pkg::*;

   logic [REG_W-1:0]  pace_reg;
   logic [REG_W-1:0]  cmref_reg;
   logic [REG_W-1:0]  pace_next;
   logic [REG_W-1:0]  cmref_next;
   logic              pready_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic              pslverr_reg;
   logic [4:0]        cm_switch_reg;
   logic              cm_internal_reg;
   logic [DRV_W-1:0]  drive_onehot_reg;
   logic              setup;
   logic              access_done;
   logic              hit_pace;
   logic              hit_cmref;
   logic              aligned;
   logic [4:0]        cm_field;
   logic [3:0]        dsel_field;

   // Byte-lane merge of a write into a stored word
   function automatic logic [REG_W-1:0] merge(
      input logic [REG_W-1:0]  old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [3:0]        strb,
      input logic [REG_W-1:0]  mask
   );
      logic [REG_W-1:0] r;
      r = old_v;
      for (int i = 0; i < LANES; i++) begin
         if (strb[i]) begin
            r[i*BYTE_W +: BYTE_W] = new_v[i*BYTE_W +: BYTE_W];
         end
      end
      merge = r & mask;
   endfunction

   // Drive electrode code to one-hot, reserved codes give none
   function automatic logic [DRV_W-1:0] drv_decode(
      input logic [3:0] code
   );
      logic [DRV_W-1:0] r;
      r = DRV_NONE;
      case (code)
         PCMC_DRV_OUT: r = DRV_ONE << 0;
         PCMC_DRV_LA:  r = DRV_ONE << 1;
         PCMC_DRV_LL:  r = DRV_ONE << 2;
         PCMC_DRV_RA:  r = DRV_ONE << 3;
         PCMC_DRV_V1:  r = DRV_ONE << 4;
         PCMC_DRV_V2:  r = DRV_ONE << 5;
         default:      r = DRV_NONE;
      endcase
      drv_decode = r;
   endfunction

   assign aligned     = (paddr[1:0] == ALIGN_OK);
   assign hit_pace    = aligned && (paddr == PACE_ADDR);
   assign hit_cmref   = aligned && (paddr == CMREF_ADDR);
   assign setup       = psel && !penable;
   assign access_done = psel && penable && pready_reg;
   assign cm_field    = cmref_reg[CM_MSB:CM_LSB];
   assign dsel_field  = cmref_reg[DSEL_MSB:DSEL_LSB];

   // masked write keeps reserved bits zero
   assign pace_next  = merge(pace_reg, pwdata, pstrb, PACE_MASK);
   assign cmref_next = merge(cmref_reg, pwdata, pstrb, CMREF_MASK);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pace_reg <= PACE_RST;
      end else if (access_done && pwrite && hit_pace) begin
         pace_reg <= pace_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmref_reg <= CMREF_RST;
      end else if (access_done && pwrite && hit_cmref) begin
         cmref_reg <= cmref_next;
      end
   end

   // One wait-free access phase, answer prepared at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !(hit_pace || hit_cmref);
         if (setup && !pwrite && hit_pace) begin
            prdata_reg <= {PAD_ZERO, pace_reg};
         end else if (setup && !pwrite && hit_cmref) begin
            prdata_reg <= {PAD_ZERO, cmref_reg};
         end else begin
            prdata_reg <= '0;
         end
      end
   end

   // Common-mode switch control from the stored selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cm_switch_reg   <= CMREF_RST[CM_MSB:CM_LSB];
         cm_internal_reg <= 1'b0;
      end else begin
         // external source opens all electrode switches
         if (cmref_reg[EXTERNAL_COMMON_MODE_SELECT_BIT]) begin
            cm_switch_reg   <= CM_NONE;
            cm_internal_reg <= 1'b0;
         end else begin
            cm_switch_reg   <= cm_field;
            // empty selection falls back to internal level
            cm_internal_reg <= (cm_field == CM_NONE);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_onehot_reg <= DRV_ONE;
      end else begin
         drive_onehot_reg <= drv_decode(dsel_field);
      end
   end

   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;
   assign pulse_width_filter_enable       = pace_reg[FILT_W_BIT];
   assign second_validation_filter_enable = pace_reg[FILT_2_BIT];
   assign first_validation_filter_enable  = pace_reg[FILT_1_BIT];
   assign detector_three_lead_select = pace_reg[SEL3_MSB:SEL3_LSB];
   assign detector_two_lead_select   = pace_reg[SEL2_MSB:SEL2_LSB];
   assign detector_one_lead_select   = pace_reg[SEL1_MSB:SEL1_LSB];
   assign detector_three_enable = pace_reg[DET3_BIT];
   assign detector_two_enable   = pace_reg[DET2_BIT];
   assign detector_one_enable   = pace_reg[DET1_BIT];
   assign cm_electrode_switch         = cm_switch_reg;
   assign internal_common_mode_level  = cm_internal_reg;
   assign external_common_mode_select = cmref_reg[EXTERNAL_COMMON_MODE_SELECT_BIT];
   // summing switches follow stored bits only
   // no automatic opening on drive disable
   assign drive_sum_switch = cmref_reg[SUM_MSB:SUM_LSB];
   assign common_electrode_reference_enable = cmref_reg[CEREF_BIT];
   assign drive_electrode_onehot = drive_onehot_reg;

   // Helper: set once any pace write has landed
   logic pace_written;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pace_written <= 1'b0;
      end else if (access_done && pwrite && hit_pace) begin
         pace_written <= 1'b1;
      end
   end

   // reset value holds until the first write
   chk_pace_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      !pace_written |-> (pace_reg == PACE_RST))
      else $error("pace register left reset value without a write");

   // write lands at the access edge, masked
   chk_pace_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (access_done && pwrite && hit_pace) |=>
         (pace_reg == $past(pace_next)))
      else $error("pace register write not stored");

   // setup read returns stored word next cycle
   chk_read_pace: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_pace) |=>
         (pready && prdata == {PAD_ZERO, $past(pace_reg)}))
      else $error("pace readback mismatch");

   // CM register keeps reserved bits zero
   chk_cmref_rsvd: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmref_reg & ~CMREF_MASK) == '0)
      else $error("reserved CM bits set");

   chk_ext_ignore: assert property (
      @(posedge pclk) disable iff (!presetn)
      cmref_reg[EXTERNAL_COMMON_MODE_SELECT_BIT] |=> (cm_electrode_switch == CM_NONE))
      else $error("electrode switches closed with external CM");

   chk_cm_internal: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!cmref_reg[EXTERNAL_COMMON_MODE_SELECT_BIT] && cm_field == CM_NONE) |=>
         internal_common_mode_level)
      else $error("internal CM level not selected");

   // switches mirror the selection one cycle later
   chk_cm_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      !cmref_reg[EXTERNAL_COMMON_MODE_SELECT_BIT] |=>
         (cm_electrode_switch == $past(cm_field)) &&
         (internal_common_mode_level == ($past(cm_field) == CM_NONE)))
      else $error("CM switches do not follow selection");

   // reserved drive codes select no electrode
   chk_drive_code: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (drive_electrode_onehot ==
         (($past(dsel_field) > PCMC_DRV_V2) ? DRV_NONE :
            (DRV_ONE << $past(dsel_field)))))
      else $error("drive electrode decode wrong");

   chk_read_cmref: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_cmref) |=>
         (pready && prdata == {PAD_ZERO, $past(cmref_reg)}))
      else $error("CM/reference readback mismatch");

   // CM/reference write lands at access edge
   chk_cmref_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (access_done && pwrite && hit_cmref) |=>
         (cmref_reg == $past(cmref_next)))
      else $error("CM/reference register write not stored");

   // unmapped access errors and reads zero
   chk_unmapped_err: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !(hit_pace || hit_cmref)) |=>
         (pready && pslverr && prdata == '0))
      else $error("unmapped access not refused");

   // refused write leaves both registers alone
   chk_refused_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (access_done && pwrite && !(hit_pace || hit_cmref)) |=>
         ($stable(pace_reg) && $stable(cmref_reg)))
      else $error("refused write changed a register");

   // ready lasts exactly one cycle per transfer
   chk_ready_once: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("pready not a single cycle");

   cov_pace_write: cover property (
      @(posedge pclk) disable iff (!presetn)
      access_done && pwrite && hit_pace);
   cov_cm_write: cover property (
      @(posedge pclk) disable iff (!presetn)
      access_done && pwrite && hit_cmref);
   cov_unmapped: cover property (
      @(posedge pclk) disable iff (!presetn)
      pready && pslverr);
   cov_ext_cm: cover property (
      @(posedge pclk) disable iff (!presetn)
      $rose(external_common_mode_select));
endmodule

// ---- sim/tb_pcmc_config.sv ----
// Self-checking bench for the pace and common-mode config register bank
module tb_pcmc_config import pcmc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [ADDR_W-1:0]   paddr;
   logic [DATA_W-1:0]   pwdata;
   logic [3:0]          pstrb;
   logic                pready;
   logic [DATA_W-1:0]   prdata;
   logic                pslverr;
   logic                filt_w;
   logic                filt_2;
   logic                filt_1;
   logic [1:0]          sel3;
   logic [1:0]          sel2;
   logic [1:0]          sel1;
   logic                det3;
   logic                det2;
   logic                det1;
   logic [4:0]          cm_sw;
   logic                int_lvl;
   logic                ext_cm;
   logic [5:0]          sum_sw;
   logic                ce_ref;
   logic [DRV_W-1:0]    drv_oh;
   logic [11:0]         pace_out;
   logic [19:0]         cm_out;
   int                  fails;
   int                  samples_checked;

   assign pace_out = {filt_w, filt_2, filt_1, sel3, sel2, sel1,
                      det3, det2, det1};
   assign cm_out   = {cm_sw, int_lvl, ext_cm, sum_sw, ce_ref, drv_oh};

   pcmc_config u_pcmc_config (
      .pclk                              (pclk),
      .presetn                           (presetn),
      .psel                              (psel),
      .penable                           (penable),
      .pwrite                            (pwrite),
      .paddr                             (paddr),
      .pwdata                            (pwdata),
      .pstrb                             (pstrb),
      .pready                            (pready),
      .prdata                            (prdata),
      .pslverr                           (pslverr),
      .pulse_width_filter_enable         (filt_w),
      .second_validation_filter_enable   (filt_2),
      .first_validation_filter_enable    (filt_1),
      .detector_three_lead_select        (sel3),
      .detector_two_lead_select          (sel2),
      .detector_one_lead_select          (sel1),
      .detector_three_enable             (det3),
      .detector_two_enable               (det2),
      .detector_one_enable               (det1),
      .cm_electrode_switch               (cm_sw),
      .internal_common_mode_level        (int_lvl),
      .external_common_mode_select       (ext_cm),
      .drive_sum_switch                  (sum_sw),
      .common_electrode_reference_enable (ce_ref),
      .drive_electrode_onehot            (drv_oh)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic print_verdict();
      if (fails == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Expected derived outputs of the CM/reference register
   function automatic logic [19:0] cm_model(input logic [23:0] v);
      logic [5:0] oh;
      logic       ext;
      ext = v[2];
      oh  = (v[7:4] < 4'd6) ? (6'h01 << v[7:4]) : 6'h00;
      return {ext ? 5'h00 : v[23:19], !ext && v[23:19] == 5'h00, ext,
              v[14:9], v[8], oh};
   endfunction

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fails++;
         $display("[FAIL] %0t no pready", $time);
         print_verdict();
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic e);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, s, rd, err);
      check(err, e, "write err");
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                        input logic e);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, 4'h0, rd, err);
      check(rd, exp, "read data");
      check(err, e, "read err");
   endtask

   task automatic pace_case(input logic [31:0] v);
      wr(PACE_ADDR, v, 4'hF, 1'b0);
      @(posedge pclk);
      check(pace_out, v[11:0], "pace fields");
      rdchk(PACE_ADDR, {8'h00, v[23:0] & PACE_MASK}, 1'b0);
   endtask

   task automatic cm_case(input logic [31:0] v);
      wr(CMREF_ADDR, v, 4'hF, 1'b0);
      @(posedge pclk);
      check(cm_out, cm_model(v[23:0]), "cm fields");
      rdchk(CMREF_ADDR, {8'h00, v[23:0] & CMREF_MASK}, 1'b0);
   endtask

   task automatic t_reset();
      @(posedge pclk);
      check(pace_out, 12'hF88, "pace reset");
      check(cm_out, cm_model(24'hE00000), "cm reset");
      rdchk(PACE_ADDR, 32'h00000F88, 1'b0);
      rdchk(CMREF_ADDR, 32'h00E00000, 1'b0);
   endtask

   task automatic t_pace();
      for (int i = 0; i < 4; i++) begin
         pace_case(32'hFF000000 | (i << 7) | (i << 5) | (i << 3) |
                   (i[0] ? 32'hE00 : 32'h0) | ((i * 5) & 7));
      end
      pace_case(32'h00000FFF);
   endtask

   task automatic t_cm();
      for (int c = 0; c < 16; c++) begin
         cm_case((32'h1 << (19 + c % 5)) | (c << 4) |
                 (c[0] ? 32'h100 : 32'h7E00));
      end
      cm_case(32'h00000000);
      cm_case(32'h00F80004);
      cm_case(32'hFFFFFFFF);
   endtask

   task automatic t_err();
      wr(12'h018, 32'hFFFFFFFF, 4'hF, 1'b1);
      rdchk(12'h018, 32'h0, 1'b1);
      wr(12'h011, 32'h0, 4'hF, 1'b1);
      rdchk(PACE_ADDR, 32'h00000FFF, 1'b0);
      // Byte lane 1 only clears bits 11..8
      wr(PACE_ADDR, 32'h0, 4'b0010, 1'b0);
      rdchk(PACE_ADDR, 32'h000000FF, 1'b0);
      wr(CMREF_ADDR, 32'h00E00000, 4'b1000, 1'b0);
      rdchk(CMREF_ADDR, 32'h00F87FF4, 1'b0);
   endtask

   initial begin
      fails           = 0;
      samples_checked = 0;
      presetn         = 1'b0;
      psel            = 1'b0;
      penable         = 1'b0;
      pwrite          = 1'b0;
      paddr           = '0;
      pwdata          = '0;
      pstrb           = 4'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_pace();
      t_cm();
      t_err();
      // Mid-run reset must restore both reset values
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      print_verdict();
   end
endmodule
